// >>> src/ssr_cfg.svh
// register offsets, field positions, reset values and timing counts of the serial slave receiver
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
// ==========================================
// register byte offsets
`define SSR_OFF_MODE 8'h00
`define SSR_OFF_COMM 8'h04
`define SSR_OFF_DATA 8'h08
`define SSR_OFF_OLVL 8'h0C
`define SSR_OFF_OEN 8'h10
`define SSR_OFF_START 8'h14
`define SSR_OFF_ISC 8'h18
`define SSR_OFF_STAT 8'h1C
`define SSR_OFF_PSC 8'h20
`define SSR_OFF_CLR 8'h24
`define SSR_OFF_STOP 8'h28
// ==========================================
// field positions
`define SSR_MODE_CKS 15
`define SSR_MODE_MD0 0
`define SSR_COMM_DAP 13
`define SSR_COMM_CKP 12
`define SSR_COMM_DIR 7
`define SSR_COMM_DLS 0
`define SSR_ISC_SSIE 7
`define SSR_START_CH0 0
`define SSR_STAT_OVF 0
`define SSR_STAT_BFF 5
`define SSR_STAT_TSF 6
// ==========================================
// reset values and masks
`define SSR_MODE_RST 16'h0000
`define SSR_COMM_RST 16'h0001
`define SSR_ISC_RST 8'h00
`define SSR_ISC_MASK 8'h83
`define SSR_PSC_RST 8'h00
`define SSR_RESP_OKAY 2'b00
`define SSR_RESP_SLVERR 2'b10
// ==========================================
// timing: pin synchroniser depth, word lengths
`define SSR_SYNC_STAGES 3
`define SSR_LEN7 4'h7
`define SSR_LEN8 4'h8
`endif

// >>> src/ssr_pkg.sv
// shared types of the serial slave receiver
package ssr_pkg;
  // ==========================================
  // shifter states
  typedef enum logic {
    SH_IDLE,
    SH_SHIFT
  } ssr_sh_e;
  // byte of shifted data
  typedef logic [7:0] ssr_byte_t;
endpackage

// >>> src/ssr_if.sv
// link between the register side and the shifter
`timescale 1ns/1ps
`default_nettype none
interface ssr_if;
  import ssr_pkg::*;
  logic mck_en; // operation clock enable pulse
  logic sck; // filtered serial clock level
  logic si; // filtered serial data level
  logic ss_active; // select gating result, high lets shifting run
  logic enable; // channel started
  logic dap; // data phase
  logic ckp; // clock polarity
  logic dir; // bit order, 1 lsb first
  logic len8; // 1 eight-bit words
  logic done; // word complete pulse
  ssr_byte_t word; // completed word
  logic last; // final bit begins pulse
  logic busy; // transfer in progress
  modport ctl (output mck_en, sck, si, ss_active, enable, dap, ckp, dir, len8,
               input done, word, last, busy);
  modport shf (input mck_en, sck, si, ss_active, enable, dap, ckp, dir, len8,
               output done, word, last, busy);
endinterface
`default_nettype wire

// >>> src/ssr_shift.sv
// serial input shifter of the slave receiver
`timescale 1ns/1ps
`default_nettype none
module ssr_shift
  import ssr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  ssr_if.shf bus
);
`include "ssr_cfg.svh"
  ssr_sh_e state_q, state_d; // shifter state
  logic [3:0] cnt_q, cnt_d; // bits taken in this word
  ssr_byte_t sr_q, sr_d; // shift register
  ssr_byte_t word_q, word_d; // last completed word
  logic prev_q, prev_d; // clock level at previous operation tick
  logic done_q, done_d; // completion pulse
  logic last_q, last_d; // final bit pulse
  logic sck_now; // clock after polarity choice
  logic samp; // sampling edge seen
  logic [3:0] nbits; // word length

  // ==========================================
  // next state: edge detect on operation clock ticks only
  always_comb begin
    sck_now = bus.sck ^ bus.ckp;
    // phase 1 samples on the opposite edge, half a clock later
    samp = bus.dap ? (prev_q & ~sck_now) : (~prev_q & sck_now);
    nbits = bus.len8 ? `SSR_LEN8 : `SSR_LEN7;
    state_d = state_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    word_d = word_q;
    done_d = 1'b0;
    last_d = 1'b0;
    // slower than the tick rate the edge is always seen
    prev_d = bus.mck_en ? sck_now : prev_q;
    case (state_q)
      SH_IDLE, SH_SHIFT: begin
        if (!bus.enable || !bus.ss_active) begin
          // select high: edges are ignored, partial word dropped
          state_d = SH_IDLE;
          cnt_d = 4'h0;
        end else if (bus.mck_en && samp) begin
          sr_d = bus.dir ? {bus.si, sr_q[7:1]} : {sr_q[6:0], bus.si};
          if (cnt_q == nbits - 4'h1) begin
            state_d = SH_IDLE;
            cnt_d = 4'h0;
            done_d = 1'b1;
            // seven-bit lsb-first words sit one place high
            if (bus.len8)
              word_d = sr_d;
            else if (bus.dir)
              word_d = {1'b0, sr_d[7:1]};
            else
              word_d = {1'b0, sr_d[6:0]};
          end else begin
            state_d = SH_SHIFT;
            cnt_d = cnt_q + 4'h1;
            last_d = (cnt_q + 4'h1 == nbits - 4'h1);
          end
        end
      end
      default: begin
        state_d = SH_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SH_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      word_q <= 8'h00;
      prev_q <= 1'b0;
      done_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      word_q <= word_d;
      prev_q <= prev_d;
      done_q <= done_d;
      last_q <= last_d;
    end
  end

  assign bus.done = done_q;
  assign bus.word = word_q;
  assign bus.last = last_q;
  assign bus.busy = (state_q == SH_SHIFT);
endmodule
`default_nettype wire

// >>> src/ssr_top.sv
// clocked serial slave receiver with its axi4-lite register slave
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ssr_top
  import ssr_pkg::*;
#(
  parameter int AW = 8 // byte address width
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SERIAL_CLOCK_PIN_I,
  input wire logic SERIAL_DATA_IN_PIN_I,
  input wire logic SLAVE_SELECT_PIN_N_I,
  output logic CHANNEL_INTERRUPT_O
);
`include "ssr_cfg.svh"

  // ==========================================
  // helpers
  // merge a 16-bit register with the low two byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0])
      r[7:0] = wd[7:0];
    if (strb[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  // prescaler tick when the low n bits of the counter are all ones
  function automatic logic tick_of(input logic [15:0] cnt, input logic [3:0] n);
    logic [15:0] mask;
    mask = 16'hFFFF << n;
    return &(cnt | mask);
  endfunction

  // ==========================================
  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] s1_q, s2_q, s3_q; // bit 0 clock, 1 data, 2 select
  logic [2:0] filt_q, filt_d; // accepted pin levels
  logic [2:0] pins; // raw pins gathered

  // filter next value
  always_comb begin
    pins = {SLAVE_SELECT_PIN_N_I, SERIAL_DATA_IN_PIN_I, SERIAL_CLOCK_PIN_I};
    filt_d = filt_q;
    for (int i = 0; i < 3; i++) begin
      if (s2_q[i] == s3_q[i])
        filt_d[i] = s3_q[i];
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1_q <= 3'b100;
      s2_q <= 3'b100;
      s3_q <= 3'b100;
      filt_q <= 3'b100; // select idles high
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // ==========================================
  // registers and bus state
  logic [15:0] mode_q, mode_d; // channel_mode
  logic [15:0] comm_q, comm_d; // channel_comm_setup
  ssr_byte_t data_q, data_d; // data_low_byte
  logic [6:0] baud_q, baud_d; // upper data register bits, kept only
  logic [15:0] olvl_q, olvl_d; // serial_output_level, unused here
  logic [15:0] oen_q, oen_d; // serial_output_enable, unused here
  logic [7:0] isc_q, isc_d; // input_switch_control
  logic [7:0] psc_q, psc_d; // prescaler_setting: a in [3:0], b in [7:4]
  logic en_q, en_d; // channel running
  logic bff_q, bff_d; // buffer_full_flag
  logic ovf_q, ovf_d; // overrun_flag
  logic md0_lat_q, md0_lat_d; // interrupt source as seen at final bit
  logic int_q, int_d; // channel_interrupt pulse
  logic [15:0] pcnt_q, pcnt_d; // prescaler counter
  logic mck_q, mck_d; // operation clock enable
  logic awr_q, awr_d; // awready
  logic wr_q, wr_d; // wready
  logic awh_q, awh_d; // write address held
  logic wh_q, wh_d; // write data held
  logic [AW-1:0] waddr_q, waddr_d; // held write address
  logic [31:0] wdata_q, wdata_d; // held write data
  logic [3:0] wstrb_q, wstrb_d; // held strobes
  logic bv_q, bv_d; // bvalid
  logic [1:0] br_q, br_d; // bresp
  logic arr_q, arr_d; // arready
  logic rv_q, rv_d; // rvalid
  logic [31:0] rd_q, rd_d; // rdata
  logic [1:0] rr_q, rr_d; // rresp
  logic do_wr; // both halves of a write held
  logic do_rd; // read address taken now
  logic rd_data_now; // data register read now
  logic [7:0] wa; // write byte offset
  logic [7:0] ra; // read byte offset

  ssr_if sif ();

  // ==========================================
  // next values of registers, flags, prescaler and bus
  always_comb begin
    mode_d = mode_q;
    comm_d = comm_q;
    data_d = data_q;
    baud_d = baud_q;
    olvl_d = olvl_q;
    oen_d = oen_q;
    isc_d = isc_q;
    psc_d = psc_q;
    en_d = en_q;
    bff_d = bff_q;
    ovf_d = ovf_q;
    md0_lat_d = md0_lat_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    br_d = br_q;
    rd_d = rd_q;
    rr_d = rr_q;
    awh_d = awh_q;
    wh_d = wh_q;
    bv_d = bv_q;
    rv_d = rv_q;
    wa = 8'(waddr_q);
    ra = 8'(S_AXI_ARADDR_I);
    // free-running prescaler; one enable picked as operation clock
    pcnt_d = pcnt_q + 16'h0001;
    mck_d = mode_q[`SSR_MODE_CKS] ? tick_of(pcnt_q, psc_q[7:4])
                                  : tick_of(pcnt_q, psc_q[3:0]);
    // address and data may come in either order
    if (S_AXI_AWVALID_I && awr_q) begin
      awh_d = 1'b1;
      waddr_d = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && wr_q) begin
      wh_d = 1'b1;
      wdata_d = S_AXI_WDATA_I;
      wstrb_d = S_AXI_WSTRB_I;
    end
    if (bv_q && S_AXI_BREADY_I)
      bv_d = 1'b0;
    do_wr = awh_q && wh_q && !bv_q;
    do_rd = S_AXI_ARVALID_I && arr_q;
    rd_data_now = do_rd && (ra == `SSR_OFF_DATA);
    // register writes
    if (do_wr) begin
      awh_d = 1'b0;
      wh_d = 1'b0;
      bv_d = 1'b1;
      br_d = `SSR_RESP_OKAY;
      case (wa)
        `SSR_OFF_MODE: mode_d = merge16(mode_q, wdata_q, wstrb_q);
        `SSR_OFF_COMM: comm_d = merge16(comm_q, wdata_q, wstrb_q);
        `SSR_OFF_DATA: begin
          // pending word is simply replaced, flag untouched
          if (wstrb_q[0])
            data_d = wdata_q[7:0];
          if (wstrb_q[1])
            baud_d = wdata_q[15:9];
        end
        `SSR_OFF_OLVL: olvl_d = merge16(olvl_q, wdata_q, wstrb_q);
        `SSR_OFF_OEN: oen_d = merge16(oen_q, wdata_q, wstrb_q);
        `SSR_OFF_START: begin
          if (wstrb_q[0] && wdata_q[`SSR_START_CH0])
            en_d = 1'b1;
        end
        `SSR_OFF_STOP: begin
          if (wstrb_q[0] && wdata_q[`SSR_START_CH0])
            en_d = 1'b0;
        end
        `SSR_OFF_ISC: begin
          if (wstrb_q[0])
            isc_d = wdata_q[7:0] & `SSR_ISC_MASK;
        end
        `SSR_OFF_PSC: begin
          if (wstrb_q[0])
            psc_d = wdata_q[7:0];
        end
        `SSR_OFF_CLR: begin
          if (wstrb_q[0] && wdata_q[`SSR_STAT_OVF])
            ovf_d = 1'b0;
        end
        `SSR_OFF_STAT: br_d = `SSR_RESP_OKAY; // read-only, write ignored
        default: br_d = `SSR_RESP_SLVERR; // unmapped
      endcase
    end
    // register reads
    if (rv_q && S_AXI_RREADY_I)
      rv_d = 1'b0;
    if (do_rd) begin
      rv_d = 1'b1;
      rr_d = `SSR_RESP_OKAY;
      case (ra)
        `SSR_OFF_MODE: rd_d = {16'h0000, mode_q};
        `SSR_OFF_COMM: rd_d = {16'h0000, comm_q};
        `SSR_OFF_DATA: rd_d = {16'h0000, baud_q, 1'b0, data_q};
        `SSR_OFF_OLVL: rd_d = {16'h0000, olvl_q};
        `SSR_OFF_OEN: rd_d = {16'h0000, oen_q};
        `SSR_OFF_START: rd_d = {31'h0000_0000, en_q};
        `SSR_OFF_STOP: rd_d = 32'h0000_0000;
        `SSR_OFF_ISC: rd_d = {24'h00_0000, isc_q};
        `SSR_OFF_PSC: rd_d = {24'h00_0000, psc_q};
        `SSR_OFF_CLR: rd_d = 32'h0000_0000;
        `SSR_OFF_STAT: begin
          rd_d = 32'h0000_0000;
          rd_d[`SSR_STAT_OVF] = ovf_q; // only error flag
          rd_d[`SSR_STAT_BFF] = bff_q;
          rd_d[`SSR_STAT_TSF] = sif.busy;
        end
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = `SSR_RESP_SLVERR;
        end
      endcase
    end
    // reading the data register frees the buffer
    if (rd_data_now)
      bff_d = 1'b0;
    // source bit freezes when the final bit starts, yet is taken again from mode in the cycle the word lands
    if (!sif.busy || sif.last)
      md0_lat_d = mode_q[`SSR_MODE_MD0];
    // word landing: sets win over read and clear in the same cycle
    if (sif.done) begin
      data_d = sif.word;
      bff_d = 1'b1;
      if (bff_q && !rd_data_now)
        ovf_d = 1'b1;
    end
    // transfer end is the only source; buffer-empty setting raises nothing
    int_d = sif.done && !md0_lat_d;
    awr_d = !awh_d && !bv_d;
    wr_d = !wh_d && !bv_d;
    arr_d = !rv_d;
  end

  // ==========================================
  // register everything
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_q <= `SSR_MODE_RST;
      comm_q <= `SSR_COMM_RST;
      data_q <= 8'h00;
      baud_q <= 7'h00;
      olvl_q <= 16'h0000;
      oen_q <= 16'h0000;
      isc_q <= `SSR_ISC_RST;
      psc_q <= `SSR_PSC_RST;
      en_q <= 1'b0;
      bff_q <= 1'b0;
      ovf_q <= 1'b0;
      md0_lat_q <= 1'b0;
      int_q <= 1'b0;
      pcnt_q <= 16'h0000;
      mck_q <= 1'b0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      awh_q <= 1'b0;
      wh_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= 2'b00;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
    end else begin
      mode_q <= mode_d;
      comm_q <= comm_d;
      data_q <= data_d;
      baud_q <= baud_d;
      olvl_q <= olvl_d;
      oen_q <= oen_d;
      isc_q <= isc_d;
      psc_q <= psc_d;
      en_q <= en_d;
      bff_q <= bff_d;
      ovf_q <= ovf_d;
      md0_lat_q <= md0_lat_d;
      int_q <= int_d;
      pcnt_q <= pcnt_d;
      mck_q <= mck_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      awh_q <= awh_d;
      wh_q <= wh_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bv_q <= bv_d;
      br_q <= br_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  // ==========================================
  // shifter hookup
  assign sif.mck_en = mck_q;
  assign sif.sck = filt_q[0];
  assign sif.si = filt_q[1];
  // pin ignored unless enabled; low level selects
  assign sif.ss_active = isc_q[`SSR_ISC_SSIE] ? ~filt_q[2] : 1'b1;
  assign sif.enable = en_q;
  assign sif.dap = comm_q[`SSR_COMM_DAP];
  assign sif.ckp = comm_q[`SSR_COMM_CKP];
  assign sif.dir = comm_q[`SSR_COMM_DIR];
  assign sif.len8 = comm_q[`SSR_COMM_DLS];

  ssr_shift u_shift (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .bus(sif)
  );

  // outputs straight from flops
  assign S_AXI_AWREADY_O = awr_q;
  assign S_AXI_WREADY_O = wr_q;
  assign S_AXI_BVALID_O = bv_q;
  assign S_AXI_BRESP_O = br_q;
  assign S_AXI_ARREADY_O = arr_q;
  assign S_AXI_RVALID_O = rv_q;
  assign S_AXI_RDATA_O = rd_q;
  assign S_AXI_RRESP_O = rr_q;
  assign CHANNEL_INTERRUPT_O = int_q;
endmodule
`default_nettype wire

// >>> verif/ssr_top_sva.sv
// port assertions of the serial slave receiver
`timescale 1ns/1ps
`default_nettype none
`include "ssr_cfg.svh"
module ssr_top_sva #(
  parameter int AW = 8 // byte address width
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SERIAL_CLOCK_PIN_I,
  input wire logic CHANNEL_INTERRUPT_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  logic sck_q; // last serial clock level
  logic [4:0] tog_q; // clock changes since last interrupt, saturating
  // ==========================================
  // change counter; an edge landing with the pulse carries over
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sck_q <= 1'b0;
      tog_q <= 5'h00;
    end else begin
      sck_q <= SERIAL_CLOCK_PIN_I;
      if (CHANNEL_INTERRUPT_O) begin
        tog_q <= {4'h0, SERIAL_CLOCK_PIN_I != sck_q};
      end else if (SERIAL_CLOCK_PIN_I != sck_q && tog_q != 5'h1F) begin
        tog_q <= tog_q + 5'h01;
      end
    end
  end
  // decoded register window, word aligned only
  function automatic logic mapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'b00) && (a <= AW'(`SSR_OFF_STOP));
  endfunction
  // ==========================================
  // register bus
  ar_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
    S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("read answer late");
  rd_code_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
    S_AXI_RRESP_O == (mapped($past(S_AXI_ARADDR_I)) ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR)
    && (mapped($past(S_AXI_ARADDR_I)) || S_AXI_RDATA_O == 32'h0000_0000))
    else $error("read response code wrong");
  r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O
    && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O)) else $error("read data moved");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
    && $stable(S_AXI_BRESP_O)) else $error("write response moved");
  aw_drop_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O)
    else $error("address ready stayed high");
  wr_timing_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O && S_AXI_BRESP_O ==
    (mapped($past(S_AXI_AWADDR_I, 2)) ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR))
    else $error("write response timing or code wrong");
  // ==========================================
  // interrupt
  irq_pulse_a: assert property (
    CHANNEL_INTERRUPT_O |=> !CHANNEL_INTERRUPT_O) else $error("interrupt longer than a cycle");
  irq_bits_a: assert property (
    CHANNEL_INTERRUPT_O |-> tog_q >= 5'd13) else $error("interrupt before a whole word");
endmodule
bind ssr_top ssr_top_sva #(.AW(AW)) u_sva (.SYS_CLK_I, .RST_N_I, .S_AXI_AWADDR_I,
  .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O,
  .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
  .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .SERIAL_CLOCK_PIN_I,
  .CHANNEL_INTERRUPT_O);
`default_nettype wire

// >>> verif/ssr_master.sv
// serial master model that clocks words into the slave receiver
`timescale 1ns/1ps
`default_nettype none
module ssr_master #(
  parameter int HALF = 8 // clocks per active serial clock phase; the idle phase between bits lasts 1.5 times as long
) (
  input wire logic clk_i,
  output logic sck_o,
  output logic si_o,
  output logic ss_n_o
);
  // ==========================================
  // idle levels at time zero
  initial begin
    sck_o <= 1'b0;
    si_o <= 1'b0;
    ss_n_o <= 1'b1;
  end
  // one word; clock stands still outside the frame
  task automatic send(input logic [7:0] w, input int n, input logic lsb,
                      input logic ckp, input logic dap, input logic hi);
    logic b;
    b = 1'b0;
    @(posedge clk_i);
    sck_o <= ckp; // idle level set before select, no stray edge
    repeat (HALF) @(posedge clk_i);
    ss_n_o <= hi; // high only where a refusal is wanted
    for (int i = 0; i < n; i++) begin
      b = lsb ? w[i] : w[n-1-i];
      if (i == 0 && !dap)
        si_o <= b; // phase 0: first bit stands before the leading edge
      repeat (HALF) @(posedge clk_i);
      sck_o <= ~ckp; // phases of at least HALF keep rate below a sixth of the tick
      repeat (HALF / 2) @(posedge clk_i);
      // bits move midway between leading and trailing edge, so a wrong-edge sampler reads a neighbour
      if (dap)
        si_o <= b;
      else if (i + 1 < n)
        si_o <= lsb ? w[i+1] : w[n-2-i];
      repeat (HALF / 2) @(posedge clk_i);
      sck_o <= ckp;
      repeat (HALF / 2) @(posedge clk_i);
    end
    repeat (HALF) @(posedge clk_i);
    ss_n_o <= 1'b1;
    si_o <= ~b; // released line shows no stale bit
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the serial slave receiver
`timescale 1ns/1ps
`default_nettype none
`include "ssr_cfg.svh"
module tb_top;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sck, si, ss_n, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] cur_comm; // setup the channel was last started with
  logic [15:0] modes [6]; // order, length, phase and polarity cases
  int err_count, cmp_count, irq_n, got;
  ssr_top #(.AW(8)) dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .SERIAL_CLOCK_PIN_I(sck), .SERIAL_DATA_IN_PIN_I(si),
    .SLAVE_SELECT_PIN_N_I(ss_n), .CHANNEL_INTERRUPT_O(irq));
  ssr_master #(.HALF(8)) u_mst (.clk_i(clk), .sck_o(sck), .si_o(si), .ss_n_o(ss_n));
  // ==========================================
  // 100 ns clock and interrupt pulse counter
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  // ==========================================
  // verdict, compare and bus tasks
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    axi_rd(a, v, rs);
    chk(v & m, exp);
  endtask
  // one word from the master; mode rewritten early in the frame
  task automatic rx(input logic [15:0] comm, input logic [15:0] md, input logic hi);
    int c0;
    if (comm !== cur_comm) begin
      wr(`SSR_OFF_STOP, 32'h0000_0001);
      wr(`SSR_OFF_COMM, {16'h0000, comm});
      wr(`SSR_OFF_START, 32'h0000_0001);
      cur_comm = comm;
    end
    c0 = irq_n;
    fork
      u_mst.send(8'hA6, comm[0] ? 8 : 7, comm[7], comm[12], comm[13], hi);
      begin
        repeat (30) @(posedge clk);
        wr(`SSR_OFF_MODE, {16'h0000, md});
      end
    join
    for (int k = 0; k < 40 && irq_n == c0; k++) @(posedge clk);
    got = irq_n - c0;
  endtask
  // ==========================================
  // hang guard, well past the few thousand cycles needed
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  // ==========================================
  // main sequence
  initial begin
    modes = '{16'h0001, 16'h0081, 16'h0000, 16'h1001, 16'h2001, 16'h3081};
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hF;
    rst_n <= 1'b0;
    cur_comm = 16'h0001;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`SSR_OFF_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`SSR_OFF_COMM, 32'hFFFF_FFFF, 32'h0000_0001);
    rdc(`SSR_OFF_ISC, 32'hFFFF_FFFF, 32'h0000_0000);
    axi_rd(8'h2C, d, r);
    chk({30'h0, r}, {30'h0, `SSR_RESP_SLVERR});
    chk(d, 32'h0000_0000);
    axi_wr(8'h2C, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, `SSR_RESP_SLVERR});
    wr(`SSR_OFF_OLVL, 32'h0000_FFFF);
    rdc(`SSR_OFF_OLVL, 32'h0000_FFFF, 32'h0000_FFFF);
    wr(`SSR_OFF_ISC, 32'h0000_0080);
    wr(`SSR_OFF_START, 32'h0000_0001);
    rdc(`SSR_OFF_START, 32'h0000_0001, 32'h0000_0001);
    foreach (modes[i]) begin
      rx(modes[i], 16'h0000, 1'b0);
      chk(32'(got), 32'h0000_0001);
      d = modes[i][0] ? 32'h0000_00A6 : 32'h0000_0026;
      rdc(`SSR_OFF_DATA, 32'h0000_FFFF, d);
      rdc(`SSR_OFF_STAT, 32'h0000_0021, 32'h0000_0000);
    end
    rx(16'h3081, 16'h0000, 1'b0);
    rx(16'h3081, 16'h0000, 1'b0);
    rdc(`SSR_OFF_STAT, 32'h0000_0021, 32'h0000_0021);
    wr(`SSR_OFF_DATA, 32'h0000_005A);
    rdc(`SSR_OFF_DATA, 32'h0000_00FF, 32'h0000_005A);
    wr(`SSR_OFF_CLR, 32'h0000_0001);
    rdc(`SSR_OFF_STAT, 32'h0000_0021, 32'h0000_0000);
    rx(16'h0001, 16'h0000, 1'b1);
    chk(32'(got), 32'h0000_0000);
    wr(`SSR_OFF_ISC, 32'h0000_0000);
    rx(16'h0001, 16'h0000, 1'b1);
    chk(32'(got), 32'h0000_0001);
    rdc(`SSR_OFF_DATA, 32'h0000_00FF, 32'h0000_00A6);
    wr(`SSR_OFF_ISC, 32'h0000_0080);
    rx(16'h0001, 16'h0001, 1'b0);
    chk(32'(got), 32'h0000_0000);
    rdc(`SSR_OFF_STAT, 32'h0000_0020, 32'h0000_0020);
    rdc(`SSR_OFF_DATA, 32'h0000_00FF, 32'h0000_00A6);
    wr(`SSR_OFF_MODE, 32'h0000_8000);
    wr(`SSR_OFF_PSC, 32'h0000_000F);
    rx(16'h0001, 16'h8000, 1'b0);
    chk(32'(got), 32'h0000_0001);
    rdc(`SSR_OFF_DATA, 32'h0000_00FF, 32'h0000_00A6);
    wr(`SSR_OFF_STOP, 32'h0000_0001);
    rdc(`SSR_OFF_START, 32'h0000_0001, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
